//--- pkg/bix_pkg.sv
/*
 * Constants for the branch and increment execute block: opcode patterns,
 * field positions, widths and reset values.
 * Assumes a single 20 MHz clock and a program memory with one-cycle read.
 */
package bix_pkg;
   localparam int          INSN_W        = 12;
   localparam int          PC_W          = 11;
   localparam int          DATA_W        = 8;
   localparam int          FADDR_W       = 5;
   // opcode patterns and masks
   localparam logic [11:0] JMP_MASK      = 12'hE00;
   localparam logic [11:0] JMP_PAT       = 12'hA00;
   localparam logic [11:0] INC_MASK      = 12'hFC0;
   localparam logic [11:0] INC_PAT       = 12'h280;
   localparam logic [11:0] INCSZ_PAT     = 12'h3C0;
   localparam logic [11:0] NOP_WORD      = 12'h000;
   // field positions
   localparam int          LIT_MSB       = 8;
   localparam int          DEST_BIT      = 5;
   localparam int          FADDR_MSB     = 4;
   localparam int          PAGE_LO       = 5;
   localparam int          PAGE_HI       = 6;
   // reset values
   localparam logic [10:0] PC_RST        = 11'h7FF;
   localparam logic [7:0]  W_RST         = 8'h00;
   typedef enum logic [1:0] {
      BIX_RESET = 2'b00,
      BIX_FETCH = 2'b01,
      BIX_EXEC  = 2'b11
   } bix_state_e;
endpackage : bix_pkg

//--- core/bix_exec.sv
/*
 * Fetch, decode and execute of jump_absolute, increment_register and
 * increment_skip_zero for an 8-bit core with 12-bit instruction words.
 * Assumes program memory returns pmem_data one cycle after pmem_addr, and the
 * register file returns file_rdata in the same cycle as file_raddr.
 */
// Summary of operation
// RULE1 - jump_absolute loads its 9-bit literal into program counter bits 8:0.
// RULE2 - jump_absolute loads program counter bits 10:9 from status page bits 6:5.
// RULE3 - jump_absolute takes two cycles, one word, touches no status flag.
// RULE4 - increment_register adds one to file, writes w or file, updates zero.
// RULE5 - increment_skip_zero increments to w or file, leaves status flags alone.
// RULE6 - zero result of increment_skip_zero discards prefetch, runs a nop, two cycles.
// RULE7 - next word prefetched during execution; taken branch flushes it, refetches.
module bix_exec (
   input  wire logic                          ref_clk,
   input  wire logic                          rstn,
   input  wire logic [bix_pkg::INSN_W-1:0]    pmem_data,
   input  wire logic [bix_pkg::DATA_W-1:0]    status_in,
   input  wire logic [bix_pkg::DATA_W-1:0]    file_rdata,
   output logic      [bix_pkg::PC_W-1:0]      pmem_addr,
   output logic      [bix_pkg::FADDR_W-1:0]   file_raddr,
   output logic                               file_we,
   output logic      [bix_pkg::FADDR_W-1:0]   file_waddr,
   output logic      [bix_pkg::DATA_W-1:0]    file_wdata,
   output logic      [bix_pkg::DATA_W-1:0]    w_out,
   output logic                               zero_we,
   output logic                               zero_val,
   output logic                               insn_done
);
   import bix_pkg::*;

   // sequencing and fetch
   bix_state_e              state_q;
   logic [PC_W-1:0]         pc_q;
   logic                    flush_q;
   // accumulator
   logic [DATA_W-1:0]       w_q;
   // strobes towards register file and status
   logic                    we_q;
   logic [FADDR_W-1:0]      waddr_q;
   logic [DATA_W-1:0]       wdata_q;
   logic                    zwe_q;
   logic                    zval_q;
   logic                    done_q;

   // decode of the executing word
   logic                    exec_en;
   logic                    is_jmp;
   logic                    is_inc;
   logic                    is_incsz;
   logic                    is_any_inc;
   logic                    to_file;
   logic [FADDR_W-1:0]      faddr;
   logic                    wr_w;
   logic                    wr_file;
   logic                    upd_zero;
   logic [DATA_W-1:0]       sum;
   logic                    sum_zero;
   logic                    taken;
   logic [PC_W-1:0]         pc_next;
   logic [PC_W-1:0]         jmp_target;
   logic [INSN_W-1:0]       cur;

   // masked compare against an opcode pattern
   function automatic logic op_match(input logic [INSN_W-1:0] w,
                                     input logic [INSN_W-1:0] m,
                                     input logic [INSN_W-1:0] p);
      op_match = (w & m) == p;
   endfunction : op_match

   function automatic logic [DATA_W-1:0] incr_data(input logic [DATA_W-1:0] v);
      incr_data = DATA_W'(v + 8'h01);
   endfunction : incr_data

   function automatic logic [PC_W-1:0] incr_pc(input logic [PC_W-1:0] v);
      incr_pc = PC_W'(v + 11'h001);
   endfunction : incr_pc

   // pmem_data holds last cycle's fetch; a flush turns it into a nop
   assign cur        = flush_q ? NOP_WORD : pmem_data;
   assign exec_en    = state_q == BIX_EXEC;

   // classify the executing word
   always_comb begin
      is_jmp   = 1'b0;
      is_inc   = 1'b0;
      is_incsz = 1'b0;
      if (op_match(cur, JMP_MASK, JMP_PAT)) begin
         is_jmp = 1'b1;
      end else if (op_match(cur, INC_MASK, INC_PAT)) begin
         is_inc = 1'b1;
      end else if (op_match(cur, INC_MASK, INCSZ_PAT)) begin
         is_incsz = 1'b1;
      end
   end

   assign is_any_inc = is_inc || is_incsz;
   assign to_file    = cur[DEST_BIT];
   assign faddr      = cur[FADDR_MSB:0];
   assign wr_w       = exec_en && is_any_inc && !to_file;
   assign wr_file    = exec_en && is_any_inc && to_file;
   assign upd_zero   = exec_en && is_inc;
   assign sum        = incr_data(file_rdata);
   assign sum_zero   = sum == 8'h00;
   // RULE1 literal into low bits
   // RULE2 page bits from status
   assign jmp_target = {status_in[PAGE_HI:PAGE_LO], cur[LIT_MSB:0]};
   // RULE6 skip when result zero
   assign taken      = is_jmp || (is_incsz && sum_zero);

   // next fetch address
   always_comb begin
      pc_next = incr_pc(pc_q);
      if (is_jmp) begin
         pc_next = jmp_target;
      end
   end

   // reset, one fetch cycle, then execute every cycle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= BIX_RESET;
      end else begin
         case (state_q)
            BIX_RESET: begin
               state_q <= BIX_FETCH;
            end
            BIX_FETCH: begin
               state_q <= BIX_EXEC;
            end
            default: begin
               state_q <= BIX_EXEC;
            end
         endcase
      end
   end

   // RULE7 prefetch during execute
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         pc_q <= PC_RST;
      end else begin
         case (state_q)
            BIX_RESET: begin
               pc_q <= PC_RST;
            end
            BIX_FETCH: begin
               pc_q <= incr_pc(pc_q);
            end
            default: begin
               // RULE1 branch redirects fetch
               pc_q <= pc_next;
            end
         endcase
      end
   end

   // RULE7 drop prefetched word
   // RULE3 jump spends nop cycle
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         flush_q <= 1'b0;
      end else begin
         flush_q <= exec_en && taken;
      end
   end

   // RULE4 d clear targets w
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         w_q <= W_RST;
      end else if (wr_w) begin
         w_q <= sum;
      end
   end

   // RULE5 d set targets register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         we_q    <= 1'b0;
         waddr_q <= '0;
         wdata_q <= '0;
      end else begin
         we_q <= wr_file;
         if (wr_file) begin
            waddr_q <= faddr;
            wdata_q <= sum;
         end
      end
   end

   // RULE4 zero flag update
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         zwe_q  <= 1'b0;
         zval_q <= 1'b0;
      end else begin
         zwe_q <= upd_zero;
         if (upd_zero) begin
            zval_q <= sum_zero;
         end
      end
   end

   // one pulse per executed cycle, flushed nop included
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         done_q <= 1'b0;
      end else begin
         done_q <= exec_en;
      end
   end

   assign pmem_addr  = pc_q;
   assign file_raddr = faddr;
   assign file_we    = we_q;
   assign file_waddr = waddr_q;
   assign file_wdata = wdata_q;
   assign w_out      = w_q;
   assign zero_we    = zwe_q;
   assign zero_val   = zval_q;
   assign insn_done  = done_q;
endmodule : bix_exec

//--- bench/bix_exec_props.sv
/* Port checker for bix_exec.
   Assumes one clock, asynchronous low reset. */
module bix_exec_props (
   input wire logic        ref_clk,
   input wire logic        rstn,
   input wire logic [11:0] pmem_data,
   input wire logic [7:0]  status_in,
   input wire logic [7:0]  file_rdata,
   input wire logic [10:0] pmem_addr,
   input wire logic [4:0]  file_raddr,
   input wire logic        file_we,
   input wire logic [4:0]  file_waddr,
   input wire logic [7:0]  file_wdata,
   input wire logic [7:0]  w_out,
   input wire logic        zero_we,
   input wire logic        zero_val,
   input wire logic        insn_done
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // non-sequential program counter step
   sequence s_jmp;
      pmem_addr != $past(pmem_addr) + 11'h001 && !$stable(pmem_addr);
   endsequence
   a_zero_value: assert property (zero_we |-> zero_val == ((file_we ? file_wdata : w_out) == 8'h00))
      else $error("zero flag value wrong");
   a_inc_data: assert property (file_we |-> file_wdata == $past(file_rdata) + 8'h01)
      else $error("write data not incremented");
   a_inc_addr: assert property (file_we |-> file_waddr == $past(file_raddr))
      else $error("write address wrong");
   a_w_dest: assert property ($changed(w_out) |-> !file_we && w_out == $past(file_rdata) + 8'h01)
      else $error("accumulator update wrong");
   a_jump_page: assert property (s_jmp |-> pmem_addr[10:9] == $past(status_in[6:5]))
      else $error("jump page bits wrong");
   a_jump_literal: assert property (s_jmp |-> pmem_addr[8:0] == $past(pmem_data[8:0]))
      else $error("jump literal bits wrong");
   a_jump_flags: assert property (s_jmp |-> !zero_we && !file_we && $stable(w_out) ##1 !zero_we && !file_we)
      else $error("jump touched flags");
   a_jump_refetch: assert property (s_jmp |=> pmem_addr == $past(pmem_addr) + 11'h001)
      else $error("jump refetch wrong");
   a_skip_nop: assert property (file_we && file_wdata == 8'h00 && !zero_we |=> !file_we && insn_done)
      else $error("skip did not run a nop");
   c_jump: cover property (s_jmp);
   c_zero: cover property (zero_we && zero_val);
   c_skip: cover property (file_we && file_wdata == 8'h00 && !zero_we);
endmodule : bix_exec_props
bind bix_exec bix_exec_props i_props (
   .ref_clk    (ref_clk),
   .rstn       (rstn),
   .pmem_data  (pmem_data),
   .status_in  (status_in),
   .file_rdata (file_rdata),
   .pmem_addr  (pmem_addr),
   .file_raddr (file_raddr),
   .file_we    (file_we),
   .file_waddr (file_waddr),
   .file_wdata (file_wdata),
   .w_out      (w_out),
   .zero_we    (zero_we),
   .zero_val   (zero_val),
   .insn_done  (insn_done)
);

//--- bench/tb_top.sv
/* Bench for bix_exec with program memory and register file models.
   Assumes reset vector 7FF and one-cycle program memory. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import bix_pkg::*;
   logic        ref_clk   = 1'b0;
   logic        rstn      = 1'b0;
   logic [11:0] pmem_data = 12'h000;
   logic [7:0]  status_in = 8'h00;
   logic [7:0]  file_rdata, file_wdata, w_out;
   logic [10:0] pmem_addr;
   logic [4:0]  file_raddr, file_waddr;
   logic        file_we, zero_we, zero_val, insn_done;
   logic [11:0] mem [2048];
   logic [7:0]  rf [32];
   logic [1:0]  zh;
   int          mismatches = 0;
   int          checked    = 0;
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) pmem_data <= mem[pmem_addr];
   always @(posedge ref_clk) if (file_we) rf[file_waddr] <= file_wdata;
   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         zh <= 2'b11;
      end else if (zero_we) begin
         zh <= {zh[0], zero_val};
      end
   end
   assign file_rdata = rf[file_raddr];
   bix_exec i_dut (
      .ref_clk    (ref_clk),
      .rstn       (rstn),
      .pmem_data  (pmem_data),
      .status_in  (status_in),
      .file_rdata (file_rdata),
      .pmem_addr  (pmem_addr),
      .file_raddr (file_raddr),
      .file_we    (file_we),
      .file_waddr (file_waddr),
      .file_wdata (file_wdata),
      .w_out      (w_out),
      .zero_we    (zero_we),
      .zero_val   (zero_val),
      .insn_done  (insn_done)
   );
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic chk_addr(input logic [10:0] g, input logic [10:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value at %0t: address %h expected %h", $time, g, e);
      end
   endtask : chk_addr
   task automatic run;
      rstn <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rstn <= 1'b1;
      repeat (30) @(posedge ref_clk);
   endtask : run
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : tally_and_finish
   task automatic sc_incr;
      mem = '{default: NOP_WORD};
      mem[0] = 12'h2A1;
      mem[1] = 12'h282;
      rf[1] = 8'hFF;
      rf[2] = 8'h7F;
      run();
      chk(rf[1], 8'h00);
      chk(w_out, 8'h80);
      chk({6'h00, zh}, 8'h02);
   endtask : sc_incr
   task automatic sc_skip;
      mem = '{default: NOP_WORD};
      mem[0] = 12'h3E3;
      mem[1] = 12'h2A4;
      mem[2] = 12'h3C5;
      rf[3] = 8'hFF;
      rf[4] = 8'h33;
      rf[5] = 8'h10;
      run();
      chk(rf[3], 8'h00);
      chk(rf[4], 8'h33);
      chk(w_out, 8'h11);
      chk({6'h00, zh}, 8'h03);
   endtask : sc_skip
   task automatic sc_jump;
      mem = '{default: NOP_WORD};
      mem[0] = 12'hA10;
      mem[1] = 12'h2A4;
      mem[2] = 12'h2A4;
      mem['h210] = 12'h2A6;
      rf[4] = 8'h33;
      rf[6] = 8'h41;
      status_in <= 8'h20;
      run();
      @(negedge ref_clk);
      chk(rf[4], 8'h33);
      chk(rf[6], 8'h42);
      chk_addr(pmem_addr, 11'h22A);
   endtask : sc_jump
   initial begin
      sc_incr();
      sc_skip();
      sc_jump();
      tally_and_finish();
   end
   initial begin
      #20000;
      mismatches++;
      tally_and_finish();
   end
endmodule : tb_top
